//--- mcx_data_ram.sv
// 128 x 4 data memory, one write port and one asynchronous read port
// Assumes single-clock use by the execute core
`timescale 1ns/10ps
`default_nettype none
module mcx_data_ram (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic we,
    input wire logic [6:0] waddr,
    input wire logic [3:0] wdata,
    // Read port
    input wire logic [6:0] raddr,
    output logic [3:0] rdata
);
    logic [3:0] mem [0:127];
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end
    assign rdata = mem[raddr];
endmodule // mcx_data_ram
`default_nettype wire

//--- mcx_exec.sv
// Execute core for jumps, display control, mode setup and memory moves
// Assumes instruction words arrive from program ROM addressed by PC_OUT,
// one instruction per clock; port pins come from outside the clock domain.
//
// Functional notes
// - Unconditional jump loads all eleven PC bits from the instruction's address field.
// - Jump if carry clear loads address when carry is zero, else PC increments.
// - Jump if nonzero branches when accumulator nonzero, else PC increments.
// - Jump if zero branches when accumulator is zero, else PC increments.
// - Two opcodes turn the display output on and off.
// - Load accumulator from direct memory word and update zero flag.
// - Load carry from bit zero of direct memory word only.
// - Hold release enable byte; bits 0,1,2,4,7 used, 3,5,6 reserved.
// - Interrupt enable byte; bits 0,1,2,4,7 used, 3,5,6 reserved.
// - Hold ends on accepted interrupt or enabled hold release event.
// - Six-bit immediate picks push-pull or open-drain per segment output group.
// - Display RAM write at 5-bit location from accumulator, working register or immediate.
// - Modulated pin waveform follows 8-bit immediate when timer1 mode bit 2 is zero.
// - Timer0 mode bit0 selects clock, bit3 runs timer, bits 1-2 reserved.
// - Timer1 mode bit0 selects internal clock, bit1 selects external source.
// - Page register low three bits pick one of eight 16-word pages.
// - Four-bit mask enables change detection per change-detect port pin.
// - Port mode bits 0-1 pick drive type, bits 2-3 enable input pull-ups.
// - Port A direction per pin, 1 input, resets to all ones.
// - Port B direction per pin, 1 input, resets to all ones.
// - Store accumulator into direct memory word, no flag changes.
// - Read port A into accumulator and memory word, update zero flag.
`timescale 1ns/10ps
`default_nettype none
module mcx_exec (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic SRST,
    // Program memory
    input wire logic [15:0] INSTR,
    output logic [10:0] PC_OUT,
    // Working register read value selected by instruction bits 3:0
    input wire logic [3:0] WR_DATA,
    // Port pins and events
    input wire logic [3:0] PORTA_PIN,
    input wire logic [3:0] CHANGE_PORT_PIN,
    input wire logic [7:0] EVENT_IN,
    input wire logic INT_ACCEPT,
    input wire logic HOLD_REQ,
    // Display RAM read side for the LCD driver
    input wire logic [4:0] LCD_RADDR,
    output logic [3:0] LCD_RDATA,
    // Status and configuration
    output logic [3:0] ACC_OUT,
    output logic CARRY_OUT,
    output logic ZERO_OUT,
    output logic HOLD_OUT,
    output logic CHANGE_EVENT,
    output logic [6:0] PAGE_BASE,
    output logic [7:0] MFP_WAVE,
    output logic MFP_FROM_IMM,
    output mcx_pkg::mcx_cfg_type CFG
);
    ////////////////////////////////////////////////////////////////////////
    // State
    logic [10:0] pc_reg, pc_next;
    logic [3:0] accumulator_reg, accumulator_next;
    logic carry_flag_reg, carry_flag_next;
    logic zero_flag_reg, zero_flag_next;
    logic hold_reg, hold_next;
    mcx_pkg::mcx_cfg_type cfg_reg, cfg_next;
    logic [3:0] pa_meta_reg, pa_sync_reg;
    logic [3:0] pc_meta_reg, pc_sync_reg, pc_prev_reg;
    logic change_reg;
    logic [3:0] lcd_rdata_reg;
    logic [3:0] ram_rdata;
    logic [3:0] lcd_rdata;

    ////////////////////////////////////////////////////////////////////////
    // Decode
    wire [10:0] jump_addr = INSTR[10:0];
    wire [6:0] ram_addr = INSTR[6:0];
    wire [4:0] lcd_addr = INSTR[8:4];
    wire [10:0] pc_inc = pc_reg + 11'h001;
    wire acc_zero = (accumulator_reg == 4'h0);

    wire is_jump_absolute = (INSTR[15:11] == mcx_pkg::OP_JMP);
    wire is_jump_carry_clear = (INSTR[15:11] == mcx_pkg::OP_JNC);
    wire is_jump_nonzero = (INSTR[15:11] == mcx_pkg::OP_JNZ);
    wire is_jump_zero = (INSTR[15:11] == mcx_pkg::OP_JZ);
    wire is_ld_acc = (INSTR[15:7] == mcx_pkg::OP_LD_ACC);
    wire is_ld_cf = (INSTR[15:7] == mcx_pkg::OP_LD_CF);
    wire is_st_acc = (INSTR[15:7] == mcx_pkg::OP_ST_ACC);
    wire is_in_pa = (INSTR[15:7] == mcx_pkg::OP_IN_PA);
    wire is_display_on_op = (INSTR == mcx_pkg::OP_DISP_ON);
    wire is_display_off_op = (INSTR == mcx_pkg::OP_DISP_OFF);
    wire is_hold_en = (INSTR[15:8] == mcx_pkg::OP_HOLD_EN);
    wire is_int_en = (INSTR[15:8] == mcx_pkg::OP_INT_EN);
    wire is_seg_drv = (INSTR[15:6] == mcx_pkg::OP_SEG_DRV);
    wire is_lcd_acc = (INSTR[15:9] == mcx_pkg::OP_LCD_ACC) && (INSTR[3:0] == 4'h0);
    wire is_lcd_wr = (INSTR[15:10] == mcx_pkg::OP_LCD_WR);
    wire is_lcd_imm = (INSTR[15:9] == mcx_pkg::OP_LCD_IMM);
    wire is_mfp = (INSTR[15:8] == mcx_pkg::OP_MFP);
    wire is_mr0 = (INSTR[15:4] == mcx_pkg::OP_MR0);
    wire is_mr1 = (INSTR[15:4] == mcx_pkg::OP_MR1);
    wire is_page = (INSTR[15:4] == mcx_pkg::OP_PAGE);
    wire is_pef = (INSTR[15:4] == mcx_pkg::OP_PEF);
    wire is_pm0 = (INSTR[15:4] == mcx_pkg::OP_PM0);
    wire is_pm1 = (INSTR[15:4] == mcx_pkg::OP_PM1);
    wire is_pm2 = (INSTR[15:4] == mcx_pkg::OP_PM2);

    // Branch selection resolved in the same cycle as the instruction
    wire take_branch = is_jump_absolute
        || (is_jump_carry_clear && !carry_flag_reg)
        || (is_jump_nonzero && !acc_zero)
        || (is_jump_zero && acc_zero);

    // Hold release from any enabled event or from interrupt acceptance
    wire [7:0] hold_hits = EVENT_IN & cfg_reg.hold_release_enable & mcx_pkg::EVENT_MASK;
    wire hold_release = (|hold_hits) || INT_ACCEPT;

    // Data memory and display memory writes
    wire ram_we = !hold_reg && (is_st_acc || is_in_pa);
    wire [3:0] ram_wdata = is_in_pa ? pa_sync_reg : accumulator_reg;
    wire lcd_we = !hold_reg && (is_lcd_acc || is_lcd_wr || is_lcd_imm);
    wire [3:0] lcd_wdata = is_lcd_wr ? WR_DATA
        : (is_lcd_imm ? INSTR[3:0] : accumulator_reg);

    // Change detection on enabled pins
    wire [3:0] pin_changed = (pc_sync_reg ^ pc_prev_reg) & cfg_reg.port_change_enable;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        pc_next = pc_reg;
        accumulator_next = accumulator_reg;
        carry_flag_next = carry_flag_reg;
        zero_flag_next = zero_flag_reg;
        hold_next = hold_reg;
        cfg_next = cfg_reg;
        if (hold_reg) begin
            if (hold_release) begin
                hold_next = 1'b0;
            end
        end else if (HOLD_REQ) begin
            hold_next = 1'b1;
            pc_next = pc_inc;
        end else begin
            pc_next = take_branch ? jump_addr : pc_inc;
            if (is_ld_acc) begin
                accumulator_next = ram_rdata;
                zero_flag_next = (ram_rdata == 4'h0);
            end
            if (is_in_pa) begin
                accumulator_next = pa_sync_reg;
                zero_flag_next = (pa_sync_reg == 4'h0);
            end
            if (is_ld_cf) begin
                carry_flag_next = ram_rdata[0];
            end
            if (is_display_on_op) begin
                cfg_next.display_on = 1'b1;
            end
            if (is_display_off_op) begin
                cfg_next.display_on = 1'b0;
            end
            if (is_hold_en) begin
                cfg_next.hold_release_enable = INSTR[7:0] & mcx_pkg::EVENT_MASK;
            end
            if (is_int_en) begin
                cfg_next.interrupt_enable_mask = INSTR[7:0] & mcx_pkg::EVENT_MASK;
            end
            if (is_seg_drv) begin
                cfg_next.segment_dc_drive_type = INSTR[5:0];
            end
            if (is_mfp) begin
                cfg_next.mfp_wave = INSTR[7:0];
            end
            if (is_mr0) begin
                cfg_next.timer0_mode = INSTR[3:0] & 4'h9;
            end
            if (is_mr1) begin
                cfg_next.timer1_mode = INSTR[3:0];
            end
            if (is_page) begin
                cfg_next.indirect_page_select = INSTR[3:0] & mcx_pkg::PAGE_MASK;
            end
            if (is_pef) begin
                cfg_next.port_change_enable = INSTR[3:0];
            end
            if (is_pm0) begin
                cfg_next.port_drive_pullup_mode = INSTR[3:0];
            end
            if (is_pm1) begin
                cfg_next.porta_direction = INSTR[3:0];
            end
            if (is_pm2) begin
                cfg_next.portb_direction = INSTR[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            pc_reg <= mcx_pkg::PC_RST;
            accumulator_reg <= mcx_pkg::NIB_RST;
            carry_flag_reg <= 1'b0;
            zero_flag_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else begin
            pc_reg <= pc_next;
            accumulator_reg <= accumulator_next;
            carry_flag_reg <= carry_flag_next;
            zero_flag_reg <= zero_flag_next;
            hold_reg <= hold_next;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            cfg_reg <= '{
                hold_release_enable: mcx_pkg::BYTE_RST,
                interrupt_enable_mask: mcx_pkg::BYTE_RST,
                segment_dc_drive_type: mcx_pkg::SEG_RST,
                timer0_mode: mcx_pkg::NIB_RST,
                timer1_mode: mcx_pkg::NIB_RST,
                indirect_page_select: mcx_pkg::NIB_RST,
                port_change_enable: mcx_pkg::NIB_RST,
                port_drive_pullup_mode: mcx_pkg::NIB_RST,
                porta_direction: mcx_pkg::DIR_RST,
                portb_direction: mcx_pkg::DIR_RST,
                mfp_wave: mcx_pkg::BYTE_RST,
                display_on: 1'b0};
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // Pin synchronisers and change detector
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            pa_meta_reg <= 4'h0;
            pa_sync_reg <= 4'h0;
            pc_meta_reg <= 4'h0;
            pc_sync_reg <= 4'h0;
            pc_prev_reg <= 4'h0;
            change_reg <= 1'b0;
        end else begin
            pa_meta_reg <= PORTA_PIN;
            pa_sync_reg <= pa_meta_reg;
            pc_meta_reg <= CHANGE_PORT_PIN;
            pc_sync_reg <= pc_meta_reg;
            pc_prev_reg <= pc_sync_reg;
            change_reg <= |pin_changed;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            lcd_rdata_reg <= 4'h0;
        end else begin
            lcd_rdata_reg <= lcd_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memories
    mcx_data_ram u_ram (
        .clk(CLOCK),
        .we(ram_we),
        .waddr(ram_addr),
        .wdata(ram_wdata),
        .raddr(ram_addr),
        .rdata(ram_rdata)
    );

    mcx_lcd_ram u_lcd (
        .clk(CLOCK),
        .we(lcd_we),
        .waddr(lcd_addr),
        .wdata(lcd_wdata),
        .raddr(LCD_RADDR),
        .rdata(lcd_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign PC_OUT = pc_reg;
    assign ACC_OUT = accumulator_reg;
    assign CARRY_OUT = carry_flag_reg;
    assign ZERO_OUT = zero_flag_reg;
    assign HOLD_OUT = hold_reg;
    assign CHANGE_EVENT = change_reg;
    assign PAGE_BASE = {cfg_reg.indirect_page_select[2:0], 4'h0};
    assign MFP_WAVE = cfg_reg.mfp_wave;
    assign MFP_FROM_IMM = !cfg_reg.timer1_mode[mcx_pkg::MR1_MFP_BIT];
    assign CFG = cfg_reg;
    assign LCD_RDATA = lcd_rdata_reg;
endmodule // mcx_exec
`default_nettype wire

//--- mcx_exec_bench.sv
// Self-checking bench for the execute core fed by a program memory model
// Assumes mcx_pkg, the core, its RAMs, mcx_rom and the checker compile first
`timescale 1ns/10ps
`default_nettype none
module mcx_exec_bench;
    typedef struct packed {
        logic [15:0] ins;
        logic [10:0] pc;
        logic [5:0] st;
    } mcx_row_type;
    logic CLOCK, SRST, INT_ACCEPT, HOLD_REQ, CARRY_OUT, ZERO_OUT, HOLD_OUT, CHANGE_EVENT, MFP_FROM_IMM, seen;
    logic [15:0] INSTR;
    logic [10:0] PC_OUT, pc_hold;
    logic [3:0] WR_DATA, PORTA_PIN, CHANGE_PORT_PIN, LCD_RDATA, ACC_OUT;
    logic [7:0] EVENT_IN, MFP_WAVE;
    logic [4:0] LCD_RADDR;
    logic [6:0] PAGE_BASE;
    mcx_pkg::mcx_cfg_type CFG;
    mcx_row_type rows [15];
    int errors;
    int checks_done;
    mcx_rom pm_u (.addr(PC_OUT), .word(INSTR));
    mcx_exec dut_u (
        .CLOCK(CLOCK), .SRST(SRST), .INSTR(INSTR), .PC_OUT(PC_OUT), .WR_DATA(WR_DATA),
        .PORTA_PIN(PORTA_PIN), .CHANGE_PORT_PIN(CHANGE_PORT_PIN), .EVENT_IN(EVENT_IN),
        .INT_ACCEPT(INT_ACCEPT), .HOLD_REQ(HOLD_REQ), .LCD_RADDR(LCD_RADDR), .LCD_RDATA(LCD_RDATA),
        .ACC_OUT(ACC_OUT), .CARRY_OUT(CARRY_OUT), .ZERO_OUT(ZERO_OUT), .HOLD_OUT(HOLD_OUT),
        .CHANGE_EVENT(CHANGE_EVENT), .PAGE_BASE(PAGE_BASE), .MFP_WAVE(MFP_WAVE),
        .MFP_FROM_IMM(MFP_FROM_IMM), .CFG(CFG)
    );
    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // Places the word at the fetch address and lets one edge execute it
    task automatic step(input logic [15:0] w);
        pm_u.mem[PC_OUT] = w;
        @(negedge CLOCK);
    endtask
    task automatic rd(input logic [4:0] a, input logic [3:0] e);
        LCD_RADDR = a;
        @(negedge CLOCK);
        chk("lcd", e, LCD_RDATA);
    endtask
    task automatic chg(input logic [3:0] p, input logic e);
        CHANGE_PORT_PIN = p;
        seen = 1'b0;
        repeat (6) begin
            @(negedge CLOCK);
            seen = seen | CHANGE_EVENT;
        end
        chk("chg", e, seen);
    endtask
    task automatic reset_dut();
        SRST = 1'b1;
        repeat (4) @(negedge CLOCK);
        SRST = 1'b0;
        chk("cfg_rst", {42'h0, 8'hFF, 9'h0}, CFG);
        chk("core_rst", 18'h0, {PC_OUT, ACC_OUT, CARRY_OUT, ZERO_OUT, HOLD_OUT});
        $display("test reset done");
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        errors = 0;
        checks_done = 0;
        SRST = 1'b1;
        WR_DATA = 4'h6;
        PORTA_PIN = 4'hB;
        CHANGE_PORT_PIN = 4'h0;
        EVENT_IN = 8'h00;
        INT_ACCEPT = 1'b0;
        HOLD_REQ = 1'b0;
        LCD_RADDR = 5'h00;
        rows[0] = {mcx_pkg::OP_JZ, 11'h123, 11'h123, 6'h00};
        rows[1] = {mcx_pkg::OP_JNZ, 11'h456, 11'h124, 6'h00};
        rows[2] = {mcx_pkg::OP_JNC, 11'h7FF, 11'h7FF, 6'h00};
        rows[3] = {mcx_pkg::OP_IN_PA, 7'h05, 11'h000, 6'h2C};
        rows[4] = {mcx_pkg::OP_JNZ, 11'h200, 11'h200, 6'h2C};
        rows[5] = {mcx_pkg::OP_JZ, 11'h300, 11'h201, 6'h2C};
        rows[6] = {mcx_pkg::OP_LD_CF, 7'h05, 11'h202, 6'h2E};
        rows[7] = {mcx_pkg::OP_JNC, 11'h100, 11'h203, 6'h2E};
        rows[8] = {mcx_pkg::OP_ST_ACC, 7'h7F, 11'h204, 6'h2E};
        rows[9] = {mcx_pkg::OP_JMP, 11'h5A5, 11'h5A5, 6'h2E};
        rows[10] = {16'hFFFF, 11'h5A6, 6'h2E};
        rows[11] = {16'hFFFF, 11'h5A7, 6'h2E};
        rows[12] = {mcx_pkg::OP_IN_PA, 7'h10, 11'h5A8, 6'h03};
        rows[13] = {mcx_pkg::OP_LD_ACC, 7'h7F, 11'h5A9, 6'h2E};
        rows[14] = {mcx_pkg::OP_LD_ACC, 7'h10, 11'h5AA, 6'h03};
        reset_dut();
        for (int i = 0; i < 15; i++) begin
            // Port pins pass a synchroniser, so they change three edges ahead
            if (i == 9) begin
                PORTA_PIN = 4'h0;
            end
            step(rows[i].ins);
            chk("pc", rows[i].pc, PC_OUT);
            chk("acc_flags", rows[i].st, {ACC_OUT, CARRY_OUT, ZERO_OUT});
        end
        $display("test rows done");
        step({mcx_pkg::OP_HOLD_EN, 8'hFF});
        step({mcx_pkg::OP_INT_EN, 8'h79});
        step({mcx_pkg::OP_SEG_DRV, 6'h2A});
        step({mcx_pkg::OP_MR0, 4'hF});
        step({mcx_pkg::OP_MR1, 4'hB});
        step({mcx_pkg::OP_PAGE, 4'hF});
        step({mcx_pkg::OP_PEF, 4'h5});
        step({mcx_pkg::OP_PM0, 4'hC});
        step({mcx_pkg::OP_PM1, 4'h3});
        step({mcx_pkg::OP_PM2, 4'h6});
        step({mcx_pkg::OP_MFP, 8'hC5});
        step(mcx_pkg::OP_DISP_ON);
        chk("cfg", {8'h97, 8'h11, 6'h2A, 4'h9, 4'hB, 4'h7, 4'h5, 4'hC, 4'h3, 4'h6, 8'hC5, 1'b1}, CFG);
        chk("page_mfp", {7'h70, 8'hC5, 1'b1}, {PAGE_BASE, MFP_WAVE, MFP_FROM_IMM});
        step(mcx_pkg::OP_DISP_OFF);
        chk("disp", 1'b0, CFG.display_on);
        $display("test config done");
        step({mcx_pkg::OP_LD_ACC, 7'h7F});
        step({mcx_pkg::OP_LCD_ACC, 5'h05, 4'h0});
        step({mcx_pkg::OP_LCD_WR, 1'b0, 5'h17, 4'h0});
        step({mcx_pkg::OP_LCD_IMM, 5'h00, 4'h9});
        rd(5'h05, 4'hB);
        rd(5'h17, 4'h6);
        rd(5'h00, 4'h9);
        $display("test display ram done");
        chg(4'h2, 1'b0);
        chg(4'h3, 1'b1);
        $display("test change detect done");
        HOLD_REQ = 1'b1;
        step(16'hFFFF);
        HOLD_REQ = 1'b0;
        pc_hold = PC_OUT;
        EVENT_IN = 8'h08;
        step({mcx_pkg::OP_JMP, 11'h000});
        EVENT_IN = 8'h10;
        chk("held", {1'b1, pc_hold}, {HOLD_OUT, PC_OUT});
        @(negedge CLOCK);
        EVENT_IN = 8'h00;
        chk("event_exit", 1'b0, HOLD_OUT);
        HOLD_REQ = 1'b1;
        step(16'hFFFF);
        HOLD_REQ = 1'b0;
        INT_ACCEPT = 1'b1;
        chk("held2", 1'b1, HOLD_OUT);
        @(negedge CLOCK);
        INT_ACCEPT = 1'b0;
        chk("int_exit", 1'b0, HOLD_OUT);
        $display("test hold done");
        reset_dut();
        complete_run();
    end
endmodule // mcx_exec_bench
`default_nettype wire

//--- mcx_exec_chk.sv
// Port-level assertions for the execute core
// Assumes one clock domain and a bind onto mcx_exec
`timescale 1ns/10ps
`default_nettype none
module mcx_exec_chk (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic SRST,
    // Fetch and events
    input wire logic [15:0] INSTR,
    input wire logic [10:0] PC_OUT,
    input wire logic [7:0] EVENT_IN,
    input wire logic INT_ACCEPT,
    input wire logic HOLD_REQ,
    // Core state
    input wire logic [3:0] ACC_OUT,
    input wire logic CARRY_OUT,
    input wire logic ZERO_OUT,
    input wire logic HOLD_OUT,
    input wire logic [6:0] PAGE_BASE,
    input wire logic MFP_FROM_IMM,
    input wire mcx_pkg::mcx_cfg_type CFG
);
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (SRST);
    // A hold request pre-empts execution apart from data and display RAM writes, so instructions only count when it is low
    wire logic run = !SRST && !HOLD_OUT && !HOLD_REQ;
    wire logic [4:0] op5 = INSTR[15:11];
    wire logic [8:0] op9 = INSTR[15:7];
    wire logic [10:0] tgt = INSTR[10:0];
    wire logic rel = INT_ACCEPT || (|(EVENT_IN & CFG.hold_release_enable));
    ////////////////////////////////////////////////////////////
    a_jump_abs: assert property (run && op5 == mcx_pkg::OP_JMP |=> PC_OUT == $past(tgt))
        else $error("absolute jump target wrong");
    a_jnc_cond: assert property (run && op5 == mcx_pkg::OP_JNC |=>
        PC_OUT == ($past(CARRY_OUT) ? $past(PC_OUT) + 11'h001 : $past(tgt)))
        else $error("carry clear jump wrong");
    a_jnz_cond: assert property (run && op5 == mcx_pkg::OP_JNZ |=>
        PC_OUT == ($past(ACC_OUT) != 4'h0 ? $past(tgt) : $past(PC_OUT) + 11'h001))
        else $error("nonzero jump wrong");
    a_jz_cond: assert property (run && op5 == mcx_pkg::OP_JZ |=>
        PC_OUT == ($past(ACC_OUT) == 4'h0 ? $past(tgt) : $past(PC_OUT) + 11'h001))
        else $error("zero jump wrong");
    a_store_quiet: assert property (run && op9 == mcx_pkg::OP_ST_ACC |=>
        $stable({ACC_OUT, CARRY_OUT, ZERO_OUT}))
        else $error("store changed state");
    a_ldcf_quiet: assert property (run && op9 == mcx_pkg::OP_LD_CF |=>
        $stable({ACC_OUT, ZERO_OUT}))
        else $error("carry load changed accumulator");
    a_zero_flag: assert property (run && (op9 == mcx_pkg::OP_LD_ACC || op9 == mcx_pkg::OP_IN_PA) |=>
        ZERO_OUT == (ACC_OUT == 4'h0))
        else $error("zero flag mismatch");
    a_hold_stay: assert property (HOLD_OUT && !rel |=> HOLD_OUT && $stable(PC_OUT))
        else $error("hold left or pc moved");
    a_hold_exit: assert property (HOLD_OUT && rel |=> !HOLD_OUT)
        else $error("hold not released");
    a_disp_ctl: assert property (run && (INSTR == mcx_pkg::OP_DISP_ON || INSTR == mcx_pkg::OP_DISP_OFF) |=>
        CFG.display_on == !$past(INSTR[7]))
        else $error("display state wrong");
    a_page_base: assert property (PAGE_BASE == {CFG.indirect_page_select[2:0], 4'h0})
        else $error("page base wrong");
    a_mask_bits: assert property (((CFG.hold_release_enable | CFG.interrupt_enable_mask) & 8'h68) == 8'h00)
        else $error("reserved enable bit set");
    a_mfp_sel: assert property (MFP_FROM_IMM == !CFG.timer1_mode[2])
        else $error("waveform select wrong");
endmodule // mcx_exec_chk
bind mcx_exec mcx_exec_chk chk_u (
    .CLOCK(CLOCK), .SRST(SRST), .INSTR(INSTR), .PC_OUT(PC_OUT), .EVENT_IN(EVENT_IN),
    .INT_ACCEPT(INT_ACCEPT), .HOLD_REQ(HOLD_REQ), .ACC_OUT(ACC_OUT), .CARRY_OUT(CARRY_OUT), .ZERO_OUT(ZERO_OUT),
    .HOLD_OUT(HOLD_OUT), .PAGE_BASE(PAGE_BASE), .MFP_FROM_IMM(MFP_FROM_IMM), .CFG(CFG)
);
`default_nettype wire

//--- mcx_lcd_ram.sv
// 24 x 4 display data memory with a write port and an external read port
// Assumes out-of-range locations are ignored on write and read as zero
`timescale 1ns/10ps
`default_nettype none
module mcx_lcd_ram (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic we,
    input wire logic [4:0] waddr,
    input wire logic [3:0] wdata,
    // Read port
    input wire logic [4:0] raddr,
    output logic [3:0] rdata
);
    logic [3:0] mem [0:mcx_pkg::LCD_DEPTH-1];
    wire in_range_w = (waddr < 5'(mcx_pkg::LCD_DEPTH));
    wire in_range_r = (raddr < 5'(mcx_pkg::LCD_DEPTH));
    always_ff @(posedge clk) begin
        if (we && in_range_w) begin
            mem[waddr] <= wdata;
        end
    end
    assign rdata = in_range_r ? mem[raddr] : 4'h0;
endmodule // mcx_lcd_ram
`default_nettype wire

//--- mcx_pkg.sv
// Package for the instruction execute slice of the 4-bit core
// Assumes a single 100 MHz clock and synchronous active-high reset
package mcx_pkg;
    localparam int PC_W = 11;
    localparam int DW = 4;
    localparam int RAM_AW = 7;
    localparam int LCD_AW = 5;
    localparam int LCD_DEPTH = 24;
    // Opcode prefixes, matched from bit 15 downward
    localparam logic [4:0] OP_JMP = 5'h0E;
    localparam logic [4:0] OP_JNC = 5'h1A;
    localparam logic [4:0] OP_JNZ = 5'h18;
    localparam logic [4:0] OP_JZ = 5'h1C;
    localparam logic [8:0] OP_LD_ACC = 9'h09D;
    localparam logic [8:0] OP_LD_CF = 9'h0B0;
    localparam logic [8:0] OP_ST_ACC = 9'h0B3;
    localparam logic [8:0] OP_IN_PA = 9'h0B6;
    localparam logic [15:0] OP_DISP_ON = 16'h0400;
    localparam logic [15:0] OP_DISP_OFF = 16'h0480;
    localparam logic [7:0] OP_HOLD_EN = 8'h41;
    localparam logic [7:0] OP_INT_EN = 8'h51;
    localparam logic [9:0] OP_SEG_DRV = 10'h018;
    localparam logic [6:0] OP_LCD_ACC = 7'h03;
    localparam logic [5:0] OP_LCD_WR = 6'h12;
    localparam logic [6:0] OP_LCD_IMM = 7'h02;
    localparam logic [7:0] OP_MFP = 8'h12;
    localparam logic [11:0] OP_MR0 = 12'h130;
    localparam logic [11:0] OP_MR1 = 12'h131;
    localparam logic [11:0] OP_PAGE = 12'h560;
    localparam logic [11:0] OP_PEF = 12'h460;
    localparam logic [11:0] OP_PM0 = 12'h530;
    localparam logic [11:0] OP_PM1 = 12'h570;
    localparam logic [11:0] OP_PM2 = 12'h5F0;
    // Field positions
    localparam int ADDR_LSB = 0;
    localparam int LCD_ADDR_LSB = 4;
    localparam int MR1_MFP_BIT = 2;
    // Reset values
    localparam logic [3:0] DIR_RST = 4'hF;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] NIB_RST = 4'h0;
    localparam logic [5:0] SEG_RST = 6'h00;
    localparam logic [10:0] PC_RST = 11'h000;
    // Valid-bit masks
    localparam logic [7:0] EVENT_MASK = 8'h97;
    localparam logic [3:0] PAGE_MASK = 4'h7;

    typedef struct packed {
        logic [7:0] hold_release_enable;
        logic [7:0] interrupt_enable_mask;
        logic [5:0] segment_dc_drive_type;
        logic [3:0] timer0_mode;
        logic [3:0] timer1_mode;
        logic [3:0] indirect_page_select;
        logic [3:0] port_change_enable;
        logic [3:0] port_drive_pullup_mode;
        logic [3:0] porta_direction;
        logic [3:0] portb_direction;
        logic [7:0] mfp_wave;
        logic display_on;
    } mcx_cfg_type;

    typedef struct packed {
        logic [7:0] hold_hit;
        logic [7:0] int_hit;
    } mcx_evt_type;
endpackage

//--- mcx_rom.sv
// Program memory model answering the fetch address combinationally
// Assumes the bench preloads words; unloaded words decode as no-ops
`timescale 1ns/10ps
`default_nettype none
module mcx_rom (
    // Fetch
    input wire logic [10:0] addr,
    output logic [15:0] word
);
    logic [15:0] mem [0:2047];
    initial begin
        for (int i = 0; i < 2048; i++) begin
            mem[i] = 16'hFFFF;
        end
    end
    assign word = mem[addr];
endmodule // mcx_rom
`default_nettype wire
